// ===== hw/bank_fsm.sv
module bank_fsm #(
    parameter int COL_BITS = bank_fsm_pkg::default_col_bits,
    parameter int BANK_ID = bank_fsm_pkg::default_bank_id
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Command pins from controller
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_bank_select_line,
    input wire logic i_autoclose_flag_line,
    input wire logic [COL_BITS-1:0] i_col,
    // Configuration from mode logic
    input wire logic [3:0] i_burst_len,
    input wire logic [1:0] i_read_latency,
    // Bank status
    output logic [2:0] o_state,
    output logic o_power_down,
    output logic o_read_data_en,
    output logic o_write_data_en,
    output logic [COL_BITS-1:0] o_col,
    output logic o_illegal
);
    initial begin
        if (COL_BITS < 1 || COL_BITS > 16 || BANK_ID < 0 || BANK_ID > 1) begin
            $error("bank_fsm: unsupported parameters");
        end
    end

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [7+COL_BITS:0] sync1;
    logic [7+COL_BITS:0] sync2;
    logic [7+COL_BITS:0] next_sync1;
    logic [7+COL_BITS:0] next_sync2;

    always_comb begin
        next_sync1 = {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
                      i_bank_select_line, i_autoclose_flag_line, 1'b0, i_col};
        next_sync2 = sync1;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= {1'b1, 1'b1, {(6+COL_BITS){1'b0}}};
            sync2 <= {1'b1, 1'b1, {(6+COL_BITS){1'b0}}};
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    logic cke;
    logic bank_sel;
    logic autoclose;
    logic [COL_BITS-1:0] col_in;
    bank_fsm_pkg::cmd_type cmd;

    assign cke = sync2[7+COL_BITS];
    assign bank_sel = sync2[2+COL_BITS];
    assign autoclose = sync2[1+COL_BITS];
    assign col_in = sync2[COL_BITS-1:0];

    cmd_decoder u_dec (
        .i_cs_n(sync2[6+COL_BITS]),
        .i_ras_n(sync2[5+COL_BITS]),
        .i_cas_n(sync2[4+COL_BITS]),
        .i_we_n(sync2[3+COL_BITS]),
        .o_cmd(cmd)
    );

    // ************************************************
    // Bank state machine
    // ************************************************
    bank_fsm_pkg::bank_state_type state;
    bank_fsm_pkg::bank_state_type next_state;
    logic [bank_fsm_pkg::cnt_bits-1:0] beats;
    logic [bank_fsm_pkg::cnt_bits-1:0] next_beats;
    logic [1:0] drain;
    logic [1:0] next_drain;
    logic cke_prev;
    logic power_down;
    logic next_power_down;
    logic illegal;
    logic next_illegal;
    logic [COL_BITS-1:0] col;
    logic [COL_BITS-1:0] next_col;
    logic mine;
    logic hit_pre;
    logic burst_last;
    logic [bank_fsm_pkg::cnt_bits-1:0] len;

    always_comb begin
        mine = (bank_sel == BANK_ID[0]);
        hit_pre = autoclose || mine;
        len = {{(bank_fsm_pkg::cnt_bits-4){1'b0}}, i_burst_len};
        burst_last = (beats <= {{(bank_fsm_pkg::cnt_bits-1){1'b0}}, 1'b1});
        next_state = state;
        next_beats = beats;
        next_col = col;
        next_illegal = 1'b0;
        next_drain = (drain != 2'h0) ? drain - 2'h1 : 2'h0;
        // Power-down entered on falling clock enable, left on rising
        next_power_down = power_down;
        if (cke_prev && !cke) begin
            next_power_down = 1'b1;
        end else if (!cke_prev && cke) begin
            next_power_down = 1'b0;
        end
        if (cke && cke_prev) begin
            case (state)
                bank_fsm_pkg::st_idle: begin
                    // Deselect, no-op, burst stop do nothing
                    if (cmd == bank_fsm_pkg::cmd_activate && mine) begin
                        next_state = bank_fsm_pkg::st_row_active;
                    end else if (mine && (cmd == bank_fsm_pkg::cmd_read ||
                                          cmd == bank_fsm_pkg::cmd_write)) begin
                        next_illegal = 1'b1;
                    end else begin
                        next_state = bank_fsm_pkg::st_idle;
                    end
                end
                bank_fsm_pkg::st_row_active,
                bank_fsm_pkg::st_read,
                bank_fsm_pkg::st_write,
                bank_fsm_pkg::st_write_recovery: begin
                    if (state == bank_fsm_pkg::st_read ||
                        state == bank_fsm_pkg::st_write) begin
                        next_beats = beats - 9'h001;
                        next_col = col + {{(COL_BITS-1){1'b0}}, 1'b1};
                        if (burst_last) begin
                            next_state = (state == bank_fsm_pkg::st_read) ?
                                bank_fsm_pkg::st_row_active :
                                bank_fsm_pkg::st_write_recovery;
                        end
                    end else if (state == bank_fsm_pkg::st_write_recovery) begin
                        next_state = bank_fsm_pkg::st_row_active;
                    end
                    if (cmd == bank_fsm_pkg::cmd_burst_stop &&
                        (state == bank_fsm_pkg::st_read ||
                         state == bank_fsm_pkg::st_write)) begin
                        next_state = bank_fsm_pkg::st_row_active;
                        next_beats = 9'h000;
                        if (state == bank_fsm_pkg::st_read) begin
                            next_drain = i_read_latency;
                        end
                    end else if (mine && cmd == bank_fsm_pkg::cmd_read) begin
                        next_state = autoclose ?
                            bank_fsm_pkg::st_read_autoclose :
                            bank_fsm_pkg::st_read;
                        next_beats = len;
                        next_col = col_in;
                    end else if (mine && cmd == bank_fsm_pkg::cmd_write) begin
                        next_state = autoclose ?
                            bank_fsm_pkg::st_write_autoclose :
                            bank_fsm_pkg::st_write;
                        next_beats = len;
                        next_col = col_in;
                    end else if (cmd == bank_fsm_pkg::cmd_precharge &&
                                 hit_pre) begin
                        next_state = bank_fsm_pkg::st_precharge;
                        next_beats = 9'h000;
                    end else if (cmd == bank_fsm_pkg::cmd_activate ||
                                 cmd == bank_fsm_pkg::cmd_refresh ||
                                 cmd == bank_fsm_pkg::cmd_load_config) begin
                        next_illegal = 1'b1;
                    end
                end
                bank_fsm_pkg::st_read_autoclose,
                bank_fsm_pkg::st_write_autoclose: begin
                    next_beats = beats - 9'h001;
                    next_col = col + {{(COL_BITS-1){1'b0}}, 1'b1};
                    if (burst_last) begin
                        next_state = bank_fsm_pkg::st_precharge;
                    end
                    if (cmd != bank_fsm_pkg::cmd_deselect &&
                        cmd != bank_fsm_pkg::cmd_nop) begin
                        next_illegal = 1'b1;
                    end
                end
                bank_fsm_pkg::st_precharge: begin
                    next_state = bank_fsm_pkg::st_idle;
                end
                default: begin
                    next_state = bank_fsm_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= bank_fsm_pkg::st_idle;
            beats <= 9'h000;
            col <= '0;
            drain <= 2'h0;
            cke_prev <= 1'b1;
            power_down <= 1'b0;
            illegal <= 1'b0;
        end else begin
            state <= next_state;
            beats <= next_beats;
            col <= next_col;
            drain <= next_drain;
            cke_prev <= cke;
            power_down <= next_power_down;
            illegal <= next_illegal;
        end
    end

    // ************************************************
    // Registered outputs
    // ************************************************
    logic next_rd_en;
    logic next_wr_en;

    always_comb begin
        next_rd_en = (next_state == bank_fsm_pkg::st_read) ||
                     (next_state == bank_fsm_pkg::st_read_autoclose) ||
                     (next_drain != 2'h0);
        next_wr_en = (next_state == bank_fsm_pkg::st_write) ||
                     (next_state == bank_fsm_pkg::st_write_autoclose);
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state <= 3'h0;
            o_power_down <= 1'b0;
            o_read_data_en <= 1'b0;
            o_write_data_en <= 1'b0;
            o_col <= '0;
            o_illegal <= 1'b0;
        end else begin
            o_state <= next_state;
            o_power_down <= next_power_down;
            o_read_data_en <= next_rd_en;
            o_write_data_en <= next_wr_en;
            o_col <= next_col;
            o_illegal <= next_illegal;
        end
    end
endmodule

// ===== shared/bank_fsm_pkg.sv
package bank_fsm_pkg;
    // ************************************************
    // Commands
    // ************************************************
    typedef enum logic [3:0] {
        cmd_deselect = 4'h0,
        cmd_nop = 4'h1,
        cmd_burst_stop = 4'h2,
        cmd_read = 4'h3,
        cmd_write = 4'h4,
        cmd_activate = 4'h5,
        cmd_precharge = 4'h6,
        cmd_refresh = 4'h7,
        cmd_load_config = 4'h8
    } cmd_type;

    // ************************************************
    // Bank states
    // ************************************************
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_row_active = 3'h1,
        st_read = 3'h2,
        st_write = 3'h3,
        st_read_autoclose = 3'h4,
        st_write_recovery = 3'h5,
        st_precharge = 3'h6,
        st_write_autoclose = 3'h7
    } bank_state_type;

    // ************************************************
    // Reset values and defaults
    // ************************************************
    localparam logic [3:0] burst_len_reset = 4'h4;
    localparam logic [1:0] read_latency_reset = 2'h2;
    localparam int default_col_bits = 8;
    localparam int default_bank_id = 0;
    localparam int cnt_bits = 9;
endpackage

// ===== hw/cmd_decoder.sv
module cmd_decoder (
    // Command pins, already synchronised
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    // Decoded command
    output bank_fsm_pkg::cmd_type o_cmd
);
    always_comb begin
        if (i_cs_n) begin
            o_cmd = bank_fsm_pkg::cmd_deselect;
        end else begin
            case ({i_ras_n, i_cas_n, i_we_n})
                3'h7: o_cmd = bank_fsm_pkg::cmd_nop;
                3'h6: o_cmd = bank_fsm_pkg::cmd_burst_stop;
                3'h5: o_cmd = bank_fsm_pkg::cmd_read;
                3'h4: o_cmd = bank_fsm_pkg::cmd_write;
                3'h3: o_cmd = bank_fsm_pkg::cmd_activate;
                3'h2: o_cmd = bank_fsm_pkg::cmd_precharge;
                3'h1: o_cmd = bank_fsm_pkg::cmd_refresh;
                3'h0: o_cmd = bank_fsm_pkg::cmd_load_config;
                default: o_cmd = bank_fsm_pkg::cmd_nop;
            endcase
        end
    end
endmodule

// ===== bench/bank_fsm_checker.sv
module bank_fsm_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Watched ports
    input wire logic i_cke,
    input wire logic [2:0] o_state,
    input wire logic o_power_down,
    input wire logic o_read_data_en,
    input wire logic o_write_data_en
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************
    // Sequences and assertions
    // ************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_to_idle;
        ##1 o_state == 3'h0;
    endsequence
    sequence s_cke_low;
        !i_cke [*5];
    endsequence
    sequence s_cke_high;
        i_cke [*5];
    endsequence
    a_precharge_one_cycle: assert property (
        o_state == 3'h6 |-> s_to_idle) else $error("precharge too long");
    a_recovery_exit: assert property (
        o_state == 3'h5 |=> o_state inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7})
        else $error("write recovery left wrongly");
    a_read_data_on: assert property (
        o_state == 3'h2 |-> o_read_data_en) else $error("read data off");
    a_write_data_on: assert property (
        o_state == 3'h3 |-> o_write_data_en) else $error("write data off");
    a_read_entry: assert property (
        o_state == 3'h2 && $past(o_state) != 3'h2
        |-> $past(o_state) inside {3'h1, 3'h3, 3'h5})
        else $error("read entered from wrong state");
    a_write_entry: assert property (
        o_state == 3'h3 && $past(o_state) != 3'h3
        |-> $past(o_state) inside {3'h1, 3'h2, 3'h5})
        else $error("write entered from wrong state");
    a_autoclose_exit: assert property (
        o_state == 3'h4 |=> o_state inside {3'h4, 3'h6})
        else $error("auto-close read left wrongly");
    a_power_down_on: assert property (
        s_cke_low |-> o_power_down) else $error("no power-down");
    a_power_down_off: assert property (
        s_cke_high |-> !o_power_down) else $error("power-down stuck");
endmodule

bind bank_fsm bank_fsm_checker bank_fsm_checker_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_cke(i_cke),
    .o_state(o_state),
    .o_power_down(o_power_down),
    .o_read_data_en(o_read_data_en),
    .o_write_data_en(o_write_data_en)
);

// ===== bench/ctrl_model.sv
module ctrl_model (
    // Request from bench
    input wire bank_fsm_pkg::cmd_type i_cmd,
    input wire logic i_autoclose,
    input wire logic [7:0] i_col,
    input wire logic i_bank,
    // Command pins
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic o_bank_select_line,
    output logic o_autoclose_flag_line,
    output logic [7:0] o_col
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pins;
    logic is_col;
    // Any requested command is encoded onto the pins, with no check against the bank state
    always_comb begin
        case (i_cmd)
            bank_fsm_pkg::cmd_nop: pins = 4'h7;
            bank_fsm_pkg::cmd_burst_stop: pins = 4'h6;
            bank_fsm_pkg::cmd_read: pins = 4'h5;
            bank_fsm_pkg::cmd_write: pins = 4'h4;
            bank_fsm_pkg::cmd_activate: pins = 4'h3;
            bank_fsm_pkg::cmd_precharge: pins = 4'h2;
            bank_fsm_pkg::cmd_refresh: pins = 4'h1;
            bank_fsm_pkg::cmd_load_config: pins = 4'h0;
            default: pins = 4'h8;
        endcase
    end
    assign is_col = pins inside {4'h4, 4'h5};
    assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = pins;
    assign o_bank_select_line = i_bank;
    assign o_autoclose_flag_line = i_autoclose;
    // Column lines show the inverted column value outside column commands
    assign o_col = is_col ? i_col : ~i_col;
endmodule

// ===== bench/bank_fsm_tb_top.sv
module bank_fsm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cke = 1'b1;
    logic [3:0] blen = 4'h4;
    bank_fsm_pkg::cmd_type cmd = bank_fsm_pkg::cmd_nop;
    logic a10 = 1'b0;
    logic [7:0] col = 8'h00;
    logic bank = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, bsel, a10_pin, pd, rd_en, wr_en, ill;
    logic [7:0] col_pin, ocol;
    logic [2:0] state;
    int fails = 0;
    int checks_done = 0;
    initial forever #10 clk = ~clk;
    ctrl_model ctrl_model_i (.i_cmd(cmd), .i_autoclose(a10), .i_col(col),
        .i_bank(bank),
        .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
        .o_bank_select_line(bsel), .o_autoclose_flag_line(a10_pin),
        .o_col(col_pin));
    bank_fsm #(.COL_BITS(8), .BANK_ID(0)) bank_fsm_i (.i_mclk(clk),
        .i_rst_n(rst_n), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
        .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_select_line(bsel),
        .i_autoclose_flag_line(a10_pin), .i_col(col_pin),
        .i_burst_len(blen), .i_read_latency(bank_fsm_pkg::read_latency_reset),
        .o_state(state), .o_power_down(pd), .o_read_data_en(rd_en),
        .o_write_data_en(wr_en), .o_col(ocol), .o_illegal(ill));
    // ************************************************
    // Helpers
    // ************************************************
    task automatic end_sim;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic issue(input bank_fsm_pkg::cmd_type c, input logic f,
        input logic [7:0] k);
        step(1);
        cmd = c;
        a10 = f;
        col = k;
        step(1);
        cmd = bank_fsm_pkg::cmd_nop;
    endtask
    task automatic wait_st(input logic [2:0] s);
        int n = 0;
        while (state !== s && n < 30) begin
            step(1);
            n++;
        end
        check("state", {5'h00, state}, {5'h00, s});
        if (state !== s)
            end_sim();
    endtask
    task automatic count_rd(input int exp);
        int n = 0;
        while (rd_en === 1'b1 && n < 40) begin
            n++;
            step(1);
        end
        check("read beats", n[7:0], exp[7:0]);
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_idle_power;
        issue(bank_fsm_pkg::cmd_deselect, 1'b0, 8'h00);
        issue(bank_fsm_pkg::cmd_burst_stop, 1'b0, 8'h00);
        step(3);
        check("idle", {5'h00, state}, 8'h00);
        cke = 1'b0;
        issue(bank_fsm_pkg::cmd_activate, 1'b0, 8'h00);
        step(4);
        check("power down", {7'h00, pd}, 8'h01);
        cke = 1'b1;
        step(5);
        check("power up", {7'h00, pd}, 8'h00);
        check("frozen", {5'h00, state}, 8'h00);
    endtask
    task automatic t_read_plain;
        issue(bank_fsm_pkg::cmd_activate, 1'b0, 8'h00);
        wait_st(3'h1);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h10);
        wait_st(3'h2);
        count_rd(4);
        check("after read", {5'h00, state}, 8'h01);
    endtask
    task automatic t_read_cut;
        blen = 4'h8;
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h20);
        wait_st(3'h2);
        issue(bank_fsm_pkg::cmd_burst_stop, 1'b0, 8'h00);
        wait_st(3'h1);
        count_rd(bank_fsm_pkg::read_latency_reset);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h20);
        wait_st(3'h2);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h40);
        step(2);
        check("read col", ocol, 8'h40);
        issue(bank_fsm_pkg::cmd_write, 1'b0, 8'h50);
        wait_st(3'h3);
        wait_st(3'h5);
        wait_st(3'h1);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h30);
        wait_st(3'h2);
        bank = 1'b1;
        issue(bank_fsm_pkg::cmd_precharge, 1'b0, 8'h00);
        bank = 1'b0;
        step(2);
        check("other bank", {5'h00, state}, 8'h02);
        issue(bank_fsm_pkg::cmd_precharge, 1'b1, 8'h00);
        wait_st(3'h6);
        step(1);
        check("closed", {5'h00, state}, 8'h00);
    endtask
    task automatic t_write_cut;
        issue(bank_fsm_pkg::cmd_activate, 1'b0, 8'h00);
        wait_st(3'h1);
        issue(bank_fsm_pkg::cmd_write, 1'b0, 8'h60);
        wait_st(3'h3);
        issue(bank_fsm_pkg::cmd_write, 1'b0, 8'h70);
        step(2);
        check("write col", ocol, 8'h70);
        issue(bank_fsm_pkg::cmd_burst_stop, 1'b0, 8'h00);
        wait_st(3'h1);
        check("write off", {7'h00, wr_en}, 8'h00);
        issue(bank_fsm_pkg::cmd_write, 1'b0, 8'h08);
        wait_st(3'h3);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h18);
        wait_st(3'h2);
        issue(bank_fsm_pkg::cmd_write, 1'b0, 8'h28);
        wait_st(3'h3);
        issue(bank_fsm_pkg::cmd_precharge, 1'b0, 8'h00);
        wait_st(3'h6);
        step(1);
        check("closed", {5'h00, state}, 8'h00);
    endtask
    task automatic t_autoclose;
        int n = 0;
        issue(bank_fsm_pkg::cmd_activate, 1'b0, 8'h00);
        wait_st(3'h1);
        issue(bank_fsm_pkg::cmd_read, 1'b1, 8'h80);
        wait_st(3'h4);
        issue(bank_fsm_pkg::cmd_burst_stop, 1'b0, 8'h00);
        while (ill !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        check("refused", {7'h00, ill}, 8'h01);
        check("kept", {5'h00, state}, 8'h04);
        wait_st(3'h6);
        step(1);
        check("closed", {5'h00, state}, 8'h00);
        issue(bank_fsm_pkg::cmd_activate, 1'b0, 8'h00);
        wait_st(3'h1);
        issue(bank_fsm_pkg::cmd_read, 1'b0, 8'h90);
        wait_st(3'h2);
        issue(bank_fsm_pkg::cmd_write, 1'b1, 8'hA0);
        wait_st(3'h7);
        wait_st(3'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        step(2);
        t_idle_power();
        t_read_plain();
        t_read_cut();
        t_write_cut();
        t_autoclose();
        end_sim();
    end
endmodule
